//--- design/tpo_timer.sv
// Behaviour
// - An 8-bit prescaler counter can sit in front of the timer count input.
// - The prescaler count is never readable or writable through a register.
// - Bypass select and a three-bit ratio come from timer control bits 3 to 0.
// - With bypass select low the prescaler feeds the timer at 1:2 up to 1:256.
// - While the prescaler is assigned, any write to the count clears the prescaler.
// - A count write leaves bypass select and ratio settings unchanged.
// - The prescaler assignment may be changed while the timer runs.
// - The overflow flag sets on a wrap FFh to 00h in 8-bit mode or FFFFh to 0000h in 16-bit mode.
// - The interrupt is held off while overflow enable, bit 5, is low; the flag still sets.
// - The timer stops in sleep, so its overflow can never wake the processor.
// - Timer control holds on, 8-bit, source, edge, bypass and three ratio bits from bit 7.
// - Interrupt control holds overflow enable at bit 5 and overflow flag at bit 2.
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
module tpo_timer (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ext_clock_in,
	input wire logic sleep,
	output logic irq
);

	tpo_pkg::tpo_timer_control_t ctrl_r;
	logic [7:0] intc_r;
	logic [7:0] cnt_lo_r;
	logic [7:0] cnt_hi_r;
	logic [7:0] hi_buf_r;
	logic ext_prev_r;
	logic irq_r;
	logic aw_held_r;
	logic w_held_r;
	logic [3:0] awaddr_r;
	logic [31:0] wdata_r;
	logic wstrb0_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic arready_r;
	logic rvalid_r;
	tpo_pkg::tpo_read_answer_t rans_r;
	tpo_pkg::tpo_read_answer_t rans_nxt;
	logic awready_r;
	logic wready_r;
	logic [7:0] hi_buf_nxt;
	logic [7:0] cnt_lo_nxt;
	logic [7:0] cnt_hi_nxt;
	tpo_pkg::tpo_timer_control_t ctrl_nxt;
	logic irq_nxt;
	logic aw_take;
	logic w_take;
	logic b_done;
	logic aw_held_nxt;
	logic w_held_nxt;
	logic bvalid_nxt;
	logic [1:0] bresp_nxt;
	logic ar_take;
	logic arready_nxt;
	logic rvalid_nxt;
	logic pre_tick;
	logic wr_any_count;
	logic hi_counts;
	logic wr_word;

	logic do_write;
	logic wr_lo;
	logic wr_hi;
	logic wr_intc;
	logic wr_ctrl;
	logic wr_known;
	logic ext_edge;
	logic src_event;
	logic tick;
	logic pre_terminal;
	logic step;
	logic [15:0] count_now;
	logic [15:0] count_inc;
	logic wrap;
	logic flag_clear;
	logic flag_set;
	logic [7:0] intc_nxt;

	function automatic logic hit(input logic [3:0] addr, input logic [3:0] reg_addr);
		hit = (addr[3:2] == reg_addr[3:2]);
	endfunction : hit

	function automatic logic aligned(input logic [3:0] addr);
		aligned = (addr[1:0] == 2'h0);
	endfunction : aligned

	assign do_write = aw_held_r && w_held_r && !bvalid_r;
	// A misaligned address is answered with an error and touches no register.
	assign wr_known = aligned(awaddr_r);
	assign wr_word = do_write && wstrb0_r && wr_known;
	assign wr_lo = wr_word && hit(awaddr_r, tpo_pkg::ADDR_TIMER_COUNT_LOW);
	assign wr_hi = wr_word && hit(awaddr_r, tpo_pkg::ADDR_TIMER_COUNT_HIGH);
	assign wr_intc = wr_word && hit(awaddr_r, tpo_pkg::ADDR_INTERRUPT_CONTROL);
	assign wr_ctrl = wr_word && hit(awaddr_r, tpo_pkg::ADDR_TIMER_CONTROL);

	// Source edge select high counts falling edges of the external input.
	assign ext_edge = ctrl_r.source_edge_select ? (ext_prev_r && !ext_clock_in)
		: (!ext_prev_r && ext_clock_in);
	assign src_event = ctrl_r.clock_source_select ? ext_edge : 1'b1;
	assign tick = ctrl_r.timer_on && !sleep && src_event;
	assign step = ctrl_r.prescaler_bypass_select ? tick : pre_terminal;
	assign pre_tick = tick && !ctrl_r.prescaler_bypass_select;
	assign wr_any_count = wr_lo || wr_hi;

	assign count_now = {cnt_hi_r, cnt_lo_r};
	assign count_inc = count_now + 16'h0001;
	assign wrap = step && (ctrl_r.eight_bit_mode_select ? (cnt_lo_r == 8'hff)
		: (count_now == 16'hffff));

	// Writing a one to the flag clears it; a new overflow in the same cycle wins.
	assign flag_clear = wr_intc && wdata_r[tpo_pkg::IC_OVERFLOW_FLAG];
	assign flag_set = wrap;
	always_comb begin
		intc_nxt = wr_intc ? wdata_r[7:0] : intc_r;
		intc_nxt[tpo_pkg::IC_OVERFLOW_FLAG] = flag_set
			|| (intc_r[tpo_pkg::IC_OVERFLOW_FLAG] && !flag_clear);
	end

	tpo_prescaler u_prescaler (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(pre_tick),
		.clear(wr_any_count),
		.prescale_ratio_select(ctrl_r.prescale_ratio_select),
		.terminal(pre_terminal)
	);

	assign ctrl_nxt = wr_ctrl ? tpo_pkg::tpo_timer_control_t'(wdata_r[7:0])
		: ctrl_r;
	assign irq_nxt = intc_nxt[tpo_pkg::IC_OVERFLOW_FLAG]
		&& intc_nxt[tpo_pkg::IC_OVERFLOW_IRQ_ENABLE];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= tpo_pkg::TIMER_CONTROL_RESET;
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			intc_r <= tpo_pkg::INTERRUPT_CONTROL_RESET;
		end else begin
			intc_r <= intc_nxt;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_prev_r <= 1'b0;
		end else begin
			ext_prev_r <= ext_clock_in;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	// High byte is written through a buffer and lands with the low byte, so a
	// 16-bit load is atomic; in 8-bit mode the high byte is not counted.
	assign hi_counts = step && !ctrl_r.eight_bit_mode_select;
	assign hi_buf_nxt = wr_hi ? wdata_r[7:0] : hi_buf_r;
	assign cnt_lo_nxt = wr_lo ? wdata_r[7:0] : (step ? count_inc[7:0] : cnt_lo_r);
	assign cnt_hi_nxt = wr_lo ? hi_buf_r : (hi_counts ? count_inc[15:8] : cnt_hi_r);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hi_buf_r <= tpo_pkg::TIMER_COUNT_RESET;
		end else begin
			hi_buf_r <= hi_buf_nxt;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_lo_r <= tpo_pkg::TIMER_COUNT_RESET;
		end else begin
			cnt_lo_r <= cnt_lo_nxt;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_hi_r <= tpo_pkg::TIMER_COUNT_RESET;
		end else begin
			cnt_hi_r <= cnt_hi_nxt;
		end
	end

	assign aw_take = s_axi_awvalid && awready_r;
	assign w_take = s_axi_wvalid && wready_r;
	assign b_done = bvalid_r && s_axi_bready;
	assign aw_held_nxt = aw_take || (aw_held_r && !b_done);
	assign w_held_nxt = w_take || (w_held_r && !b_done);
	assign bvalid_nxt = do_write || (bvalid_r && !s_axi_bready);
	assign bresp_nxt = do_write ? (wr_known ? tpo_pkg::RESP_OKAY : tpo_pkg::RESP_SLVERR) : bresp_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
		end else begin
			aw_held_r <= aw_held_nxt;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b1;
		end else begin
			awready_r <= !aw_held_nxt;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awaddr_r <= 4'h0;
		end else if (aw_take) begin
			awaddr_r <= s_axi_awaddr;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
		end else begin
			w_held_r <= w_held_nxt;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready_r <= 1'b1;
		end else begin
			wready_r <= !w_held_nxt;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdata_r <= 32'h00000000;
		end else if (w_take) begin
			wdata_r <= s_axi_wdata;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wstrb0_r <= 1'b0;
		end else if (w_take) begin
			wstrb0_r <= s_axi_wstrb[0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
		end else begin
			bvalid_r <= bvalid_nxt;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bresp_r <= tpo_pkg::RESP_OKAY;
		end else begin
			bresp_r <= bresp_nxt;
		end
	end

	// Only the four register words answer OKAY; a misaligned address reads zero with SLVERR.
	always_comb begin
		rans_nxt.data = 32'h00000000;
		rans_nxt.resp = tpo_pkg::RESP_OKAY;
		if (!aligned(s_axi_araddr)) begin
			rans_nxt.resp = tpo_pkg::RESP_SLVERR;
		end else if (hit(s_axi_araddr, tpo_pkg::ADDR_TIMER_COUNT_LOW)) begin
			rans_nxt.data = {24'h000000, cnt_lo_r};
		end else if (hit(s_axi_araddr, tpo_pkg::ADDR_TIMER_COUNT_HIGH)) begin
			rans_nxt.data = {24'h000000, cnt_hi_r};
		end else if (hit(s_axi_araddr, tpo_pkg::ADDR_INTERRUPT_CONTROL)) begin
			rans_nxt.data = {24'h000000, intc_r};
		end else begin
			rans_nxt.data = {24'h000000, ctrl_r};
		end
	end

	assign ar_take = s_axi_arvalid && arready_r;
	assign arready_nxt = s_axi_arvalid && !arready_r && !rvalid_r;
	assign rvalid_nxt = ar_take || (rvalid_r && !s_axi_rready);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b0;
		end else begin
			arready_r <= arready_nxt;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= rvalid_nxt;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rans_r <= '0;
		end else if (ar_take) begin
			rans_r <= rans_nxt;
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rans_r.data;
	assign s_axi_rresp = rans_r.resp;
	assign irq = irq_r;

endmodule : tpo_timer

//--- design/tpo_pkg.sv
package tpo_pkg;

	localparam logic [3:0] ADDR_TIMER_COUNT_LOW = 4'h0;
	localparam logic [3:0] ADDR_TIMER_COUNT_HIGH = 4'h4;
	localparam logic [3:0] ADDR_INTERRUPT_CONTROL = 4'h8;
	localparam logic [3:0] ADDR_TIMER_CONTROL = 4'hc;

	localparam int TC_TIMER_ON = 7;
	localparam int TC_EIGHT_BIT = 6;
	localparam int TC_CLOCK_SOURCE = 5;
	localparam int TC_SOURCE_EDGE = 4;
	localparam int TC_BYPASS = 3;
	localparam int TC_RATIO_MSB = 2;

	localparam int IC_OVERFLOW_IRQ_ENABLE = 5;
	localparam int IC_OVERFLOW_FLAG = 2;

	localparam logic [7:0] TIMER_CONTROL_RESET = 8'hff;
	localparam logic [7:0] INTERRUPT_CONTROL_RESET = 8'h00;
	localparam logic [7:0] TIMER_COUNT_RESET = 8'h00;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic timer_on;
		logic eight_bit_mode_select;
		logic clock_source_select;
		logic source_edge_select;
		logic prescaler_bypass_select;
		logic [2:0] prescale_ratio_select;
	} tpo_timer_control_t;

	typedef struct packed {
		logic [31:0] data;
		logic [1:0] resp;
	} tpo_read_answer_t;

endpackage : tpo_pkg

//--- design/tpo_prescaler.sv
module tpo_prescaler (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tick,
	input wire logic clear,
	input wire logic [2:0] prescale_ratio_select,
	output logic terminal
);

	// Count stays hidden from software; only a clear reaches it.
	logic [7:0] count_r;
	logic [7:0] count_nxt;
	logic [7:0] ratio_mask;

	assign ratio_mask = 8'((9'h002 << prescale_ratio_select) - 9'h001);
	assign count_nxt = clear ? 8'h00 : (tick ? count_r + 8'h01 : count_r);
	assign terminal = tick && ((count_r & ratio_mask) == ratio_mask);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_r <= 8'h00;
		end else begin
			count_r <= count_nxt;
		end
	end

endmodule : tpo_prescaler

//--- sim/tpo_timer_assertions.sv
module tpo_timer_assertions (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire logic aw_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	chk_write_answer: assert property (aw_hs |-> ##[1:2] s_axi_bvalid)
		else $error("write not answered");
	chk_write_bad_addr: assert property (aw_hs && s_axi_awaddr[1:0] != 2'h0
		|-> ##[1:2] (s_axi_bvalid && s_axi_bresp == tpo_pkg::RESP_SLVERR)) else $error("no slverr");
	chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	chk_ready_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("ready while answering");
	chk_arready_pulse: assert property (s_axi_arready |=> !s_axi_arready)
		else $error("arready too long");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
		else $error("read not answered");
	chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
	chk_byte_wide: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	cover property (aw_hs);
	cover property (s_axi_bvalid && s_axi_bresp == tpo_pkg::RESP_SLVERR);
	cover property ($rose(irq));
endmodule : tpo_timer_assertions

bind tpo_timer tpo_timer_assertions i_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .irq);

//--- sim/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] CL = tpo_pkg::ADDR_TIMER_COUNT_LOW;
	localparam logic [3:0] CH = tpo_pkg::ADDR_TIMER_COUNT_HIGH;
	localparam logic [3:0] IC = tpo_pkg::ADDR_INTERRUPT_CONTROL;
	localparam logic [3:0] TC = tpo_pkg::ADDR_TIMER_CONTROL;
	logic aclk = 1'b0, aresetn = 1'b0, sleep = 1'b1, ext_clock_in = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	int n_mismatch = 0, n_compared = 0;
	always #5 aclk = ~aclk;
	tpo_timer i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_clock_in, .sleep, .irq);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, {24'h0, d});
		chk({30'h0, s_axi_rresp}, {30'h0, er});
	endtask : rd
	// Sleep gates the count, so exactly n ticks reach the timer per call.
	task automatic run(input int n);
		@(posedge aclk);
		sleep <= 1'b0;
		repeat (n) @(posedge aclk);
		sleep <= 1'b1;
	endtask : run
	task automatic t_reset();
		rd(TC, tpo_pkg::TIMER_CONTROL_RESET);
		rd(IC, tpo_pkg::INTERRUPT_CONTROL_RESET);
		rd(CH, tpo_pkg::TIMER_COUNT_RESET);
		wr(4'h1, 8'h55, tpo_pkg::RESP_SLVERR);
		rd(4'h6, 8'h00, tpo_pkg::RESP_SLVERR);
		rd(CL, tpo_pkg::TIMER_COUNT_RESET);
		$display("reset test done");
	endtask : t_reset
	task automatic t_prescale();
		int k;
		for (int r = 0; r < 8; r++) begin
			k = 2 << r;
			wr(TC, 8'hc0 | r[7:0]);
			run(k - 1);
			wr(CL, 8'h00);
			run(3 * k + k / 2);
			rd(CL, 8'h03);
			rd(TC, 8'hc0 | r[7:0]);
		end
		$display("prescale test done");
	endtask : t_prescale
	task automatic t_overflow();
		wr(IC, 8'h00);
		wr(TC, 8'hc8);
		wr(CL, 8'hfe);
		run(2);
		rd(CL, 8'h00);
		rd(IC, 8'h04);
		chk({31'h0, irq}, 32'h0);
		wr(IC, 8'h20);
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, 32'h1);
		wr(IC, 8'h24);
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, 32'h0);
		wr(TC, 8'h88);
		wr(CH, 8'hff);
		wr(CL, 8'hfe);
		run(1);
		repeat (20) @(posedge aclk);
		rd(CL, 8'hff);
		chk({31'h0, irq}, 32'h0);
		run(1);
		rd(CH, 8'h00);
		rd(IC, 8'h24);
		chk({31'h0, irq}, 32'h1);
		$display("overflow test done");
	endtask : t_overflow
	// Three pulses on the external input, counted on rising and then on falling edges.
	task automatic t_external();
		for (int e = 0; e < 2; e++) begin
			wr(TC, e ? 8'hf8 : 8'he8);
			wr(CL, 8'h00);
			@(posedge aclk);
			sleep <= 1'b0;
			repeat (3) begin
				@(posedge aclk);
				ext_clock_in <= 1'b1;
				@(posedge aclk);
				ext_clock_in <= 1'b0;
			end
			@(posedge aclk);
			sleep <= 1'b1;
			rd(CL, 8'h03);
		end
		$display("external test done");
	endtask : t_external
	task automatic end_of_test();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_of_test
	initial begin
		repeat (20000) @(posedge aclk);
		n_mismatch++;
		$display("ERROR %0t: watchdog expired", $time);
		end_of_test();
	end
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_prescale();
		t_overflow();
		t_external();
		end_of_test();
	end
endmodule : testbench
